// ---- logic/txo_pkg.sv ----
package txo_pkg;
  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [13:0] TBL_OP_HI   = 14'h0002;
  localparam logic [13:0] TBLWR_OP_HI = 14'h0003;
  localparam logic [7:0]  XORL_HI     = 8'h0A;
  localparam logic [5:0]  XORF_HI     = 6'h06;
  localparam logic [6:0]  TSTZ_HI     = 7'h33;
  // ****************************************
  // Pointer modes
  // ****************************************
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_POST_INC = 2'h1;
  localparam logic [1:0] PM_POST_DEC = 2'h2;
  localparam logic [1:0] PM_PRE_INC = 2'h3;
  localparam int unsigned TP_W = 21;
  typedef enum logic [3:0] {
    TXO_Q1 = 4'h1, TXO_Q2 = 4'h2, TXO_Q3 = 4'h4, TXO_Q4 = 4'h8
  } txo_q_t;
  typedef struct packed {
    logic       zero;
    logic       neg;
  } txo_flags_t;
endpackage : txo_pkg

// ---- logic/txo_core.sv ----
// Function
// - Table write is 0000 0000 0000 11nn, nn picking the pointer mode.
// - Table write is one word over two instruction cycles.
// - Cycle two of a write moves the latch byte to holding at the pointer.
// - Cycle two of a read latches the program byte at the pointer.
// - Test-skip-zero reads in Q2, tests in Q3, writes nothing in Q4.
// - Xor literal 0000 1010 kkkk kkkk writes working xor literal back.
// - Xor instructions change only the negative and zero flags.
// - Register-form xor writes working xor file to the d destination.
// - Register-form xor decodes from 0001 10da.
`timescale 1ns/1ns
`default_nettype none
module txo_core (
  // Clock and control
  input  wire logic                    i_mclk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  // Instruction
  input  wire logic                    i_instr_vld,
  input  wire logic [15:0]             i_instr,
  input  wire logic                    i_next_two_word,
  input  wire logic [7:0]              i_wreg,
  input  wire logic [7:0]              i_file_rdata,
  input  wire logic [15:0]             i_prog_word,
  // Outputs
  output logic                         o_busy,
  output logic [txo_pkg::TP_W-1:0]     o_table_pointer,
  output logic [7:0]                   o_table_latch,
  output logic                         o_hold_we,
  output logic [txo_pkg::TP_W-1:0]     o_hold_addr,
  output logic [7:0]                   o_hold_data,
  output logic                         o_file_re,
  output logic [8:0]                   o_file_addr,
  output logic                         o_file_we,
  output logic [7:0]                   o_file_wdata,
  output logic                         o_wreg_we,
  output logic [7:0]                   o_wreg_wdata,
  output logic                         o_flag_we,
  output txo_pkg::txo_flags_t          o_flags,
  output logic                         o_skip
);
  txo_pkg::txo_q_t q_q;
  logic [15:0] ir_q;
  logic        second_q, ext_q, skip_pend_q, tst_q;
  logic [1:0]  skip_cnt_q;
  logic        is_rd, is_wr, is_xl, is_xf, is_ts;
  logic [7:0]  res;
  logic        tbl_start, tbl_end;

  // ****************************************
  // Decode
  // ****************************************
  assign is_rd = (ir_q[15:2] == txo_pkg::TBL_OP_HI);
  assign is_wr = (ir_q[15:2] == txo_pkg::TBLWR_OP_HI);
  assign is_xl = (ir_q[15:8] == txo_pkg::XORL_HI);
  assign is_xf = (ir_q[15:10] == txo_pkg::XORF_HI);
  assign is_ts = (ir_q[15:9] == txo_pkg::TSTZ_HI);
  assign res = i_wreg ^ (is_xl ? ir_q[7:0] : i_file_rdata);
  // End of first and of second cycle of a table access
  assign tbl_start = (q_q == txo_pkg::TXO_Q4) && (is_rd || is_wr)
                   && !second_q && !ext_q;
  assign tbl_end   = (q_q == txo_pkg::TXO_Q4) && (is_rd || is_wr) && second_q;

  // ****************************************
  // Quadrature sequencer
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) q_q <= txo_pkg::TXO_Q1;
    else if (i_ce) begin
      case (q_q)
        txo_pkg::TXO_Q1: q_q <= txo_pkg::TXO_Q2;
        txo_pkg::TXO_Q2: q_q <= txo_pkg::TXO_Q3;
        txo_pkg::TXO_Q3: q_q <= txo_pkg::TXO_Q4;
        txo_pkg::TXO_Q4: q_q <= txo_pkg::TXO_Q1;
        default:         q_q <= txo_pkg::TXO_Q1;
      endcase
    end
  end

  // Instruction register, second-cycle and skip state
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ir_q <= 16'h0000;
      second_q <= 1'b0;
      ext_q <= 1'b0;
      skip_cnt_q <= 2'h0;
      skip_pend_q <= 1'b0;
    end else if (i_ce && q_q == txo_pkg::TXO_Q4) begin
      ext_q <= 1'b0;
      if ((is_rd || is_wr) && !second_q && !ext_q) begin
        second_q <= 1'b1;
        ext_q <= 1'b1;
      end else begin
        second_q <= 1'b0;
        if (skip_pend_q) begin
          // This slot is already the no-op; a second word costs one more
          skip_cnt_q <= i_next_two_word ? 2'h1 : 2'h0;
          ir_q <= 16'h0000;
          skip_pend_q <= 1'b0;
        end else if (skip_cnt_q != 2'h0) begin
          skip_cnt_q <= skip_cnt_q - 2'h1;
          ir_q <= 16'h0000;
        end else begin
          ir_q <= i_instr_vld ? i_instr : 16'h0000;
        end
      end
    end else if (i_ce && q_q == txo_pkg::TXO_Q3 && tst_q
                 && i_file_rdata == 8'h00 && skip_cnt_q == 2'h0) begin
      skip_pend_q <= 1'b1;
    end
  end

  // ****************************************
  // Register file access
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_file_re <= 1'b0;
      o_file_addr <= 9'h000;
      tst_q <= 1'b0;
    end else if (i_ce) begin
      o_file_re <= (q_q == txo_pkg::TXO_Q1) && skip_cnt_q == 2'h0
                   && (is_ts || is_xf);
      o_file_addr <= {ir_q[8], ir_q[7:0]};
      // Held from Q1 to the next Q1 so the Q3 test still sees it
      if (q_q == txo_pkg::TXO_Q1) begin
        tst_q <= is_ts && skip_cnt_q == 2'h0;
      end
    end
  end

  // Xor results; only N and Z touched
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_wreg_we <= 1'b0;
      o_wreg_wdata <= 8'h00;
      o_file_we <= 1'b0;
      o_file_wdata <= 8'h00;
      o_flag_we <= 1'b0;
      o_flags <= '0;
    end else if (i_ce) begin
      o_wreg_we <= 1'b0;
      o_file_we <= 1'b0;
      o_flag_we <= 1'b0;
      if (q_q == txo_pkg::TXO_Q3 && skip_cnt_q == 2'h0
          && (is_xl || is_xf)) begin
        o_wreg_we <= is_xl || !ir_q[9];
        o_file_we <= is_xf && ir_q[9];
        o_wreg_wdata <= res;
        o_file_wdata <= res;
        o_flag_we <= 1'b1;
        o_flags <= '{zero: res == 8'h00, neg: res[7]};
      end
    end
  end

  // ****************************************
  // Table access
  // ****************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_table_pointer <= '0;
      o_table_latch <= 8'h00;
      o_hold_we <= 1'b0;
      o_hold_addr <= '0;
      o_hold_data <= 8'h00;
    end else if (i_ce) begin
      o_hold_we <= 1'b0;
      // Pre-increment moves the pointer before cycle two, so memory
      // always sees the access address on the pointer output
      if (tbl_start && ir_q[1:0] == txo_pkg::PM_PRE_INC) begin
        o_table_pointer <= o_table_pointer + 1'b1;
      end
      if (tbl_end && is_rd) begin
        o_table_latch <= o_table_pointer[0] ? i_prog_word[15:8]
                                            : i_prog_word[7:0];
      end
      if (tbl_end && is_wr) begin
        o_hold_we <= 1'b1;
        o_hold_addr <= o_table_pointer;
        o_hold_data <= o_table_latch;
      end
      if (tbl_end) begin
        case (ir_q[1:0])
          txo_pkg::PM_POST_INC: o_table_pointer <= o_table_pointer + 1'b1;
          txo_pkg::PM_POST_DEC: o_table_pointer <= o_table_pointer - 1'b1;
          txo_pkg::PM_NONE:     o_table_pointer <= o_table_pointer;
          default:              o_table_pointer <= o_table_pointer;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_busy <= 1'b0;
      o_skip <= 1'b0;
    end else if (i_ce) begin
      o_busy <= second_q || skip_cnt_q != 2'h0;
      o_skip <= skip_pend_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_wr_hold;
    @(posedge i_mclk) disable iff (i_srst)
      o_hold_we |-> o_hold_data == $past(o_table_latch);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("hold data");
  property p_flags;
    @(posedge i_mclk) disable iff (i_srst)
      o_flag_we |-> o_flags.zero == (o_wreg_wdata == 8'h00);
  endproperty
  a_flags: assert property (p_flags) else $error("zero flag");
  property p_dest;
    @(posedge i_mclk) disable iff (i_srst)
      !(o_wreg_we && o_file_we);
  endproperty
  a_dest: assert property (p_dest) else $error("two dests");
  property p_rd_q2;
    @(posedge i_mclk) disable iff (i_srst)
      o_file_re |-> q_q == txo_pkg::TXO_Q2;
  endproperty
  a_rd_q2: assert property (p_rd_q2) else $error("read phase");
  property p_skip_nop;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      o_skip |-> ##1 (!o_wreg_we && !o_file_we && !o_file_re) [*4];
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip slot");
  property p_tbl_two;
    @(posedge i_mclk) disable iff (i_srst || !i_ce)
      $rose(second_q) |-> second_q [*4] ##1 !second_q;
  endproperty
  a_tbl_two: assert property (p_tbl_two) else $error("table cycles");
  property p_flag_pair;
    @(posedge i_mclk) disable iff (i_srst)
      o_flag_we |-> (o_wreg_we || o_file_we)
                    && o_flags.neg == o_wreg_wdata[7];
  endproperty
  a_flag_pair: assert property (p_flag_pair) else $error("neg flag");
  c_hold: cover property (@(posedge i_mclk) o_hold_we);
  c_skip: cover property (@(posedge i_mclk) o_skip);
  c_xor: cover property (@(posedge i_mclk) o_flag_we);
endmodule : txo_core
`default_nettype wire

// ---- test/txo_pmem.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Program memory and holding register
// ****************************************
module txo_pmem (
  // Core side
  input  wire logic                     i_mclk,
  input  wire logic [txo_pkg::TP_W-1:0] i_tp,
  input  wire logic                     i_we,
  input  wire logic [txo_pkg::TP_W-1:0] i_wa,
  input  wire logic [7:0]               i_wd,
  // Word read and last holding write
  output logic      [15:0]              o_word,
  output logic      [txo_pkg::TP_W-1:0] o_wa,
  output logic      [7:0]               o_wd
);
  // Lanes differ so a swapped byte select is seen
  assign o_word = {i_tp[8:1] ^ 8'hC3, ~i_tp[8:1]};
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      o_wa <= i_wa;
      o_wd <= i_wd;
    end
  end
endmodule : txo_pmem
`default_nettype wire

// ---- test/table_access_xor_test_ops_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module table_access_xor_test_ops_tb;
  logic i_mclk = 0, i_srst = 1, i_ce = 1, i_instr_vld = 0, i_next_two_word = 0;
  logic [15:0] i_instr = '0, pw;
  logic [7:0] i_wreg = '0, i_file_rdata = '0, wr_q, wd, o_table_latch;
  logic [7:0] o_hold_data, o_file_wdata, o_wreg_wdata;
  logic [20:0] o_table_pointer, o_hold_addr, wa;
  logic [8:0] o_file_addr, ra_q;
  logic o_busy, o_hold_we, o_file_re, o_file_we, o_wreg_we, o_flag_we, o_skip;
  logic wr_f;
  txo_pkg::txo_flags_t o_flags, fl_q;
  int n_mismatch = 0, checks_done = 0, n_wr = 0, n_skip = 0, n_busy = 0;
  txo_core txo_core_inst (.i_mclk, .i_srst, .i_ce, .i_instr_vld, .i_instr,
    .i_next_two_word, .i_wreg, .i_file_rdata, .i_prog_word(pw), .o_busy,
    .o_table_pointer, .o_table_latch, .o_hold_we, .o_hold_addr, .o_hold_data,
    .o_file_re, .o_file_addr, .o_file_we, .o_file_wdata, .o_wreg_we,
    .o_wreg_wdata, .o_flag_we, .o_flags, .o_skip);
  txo_pmem txo_pmem_inst (.i_mclk, .i_tp(o_table_pointer), .i_we(o_hold_we),
    .i_wa(o_hold_addr), .i_wd(o_hold_data), .o_word(pw), .o_wa(wa), .o_wd(wd));
  initial forever #20 i_mclk = ~i_mclk;
  // ****************************************
  // Monitor, drivers and checks
  // ****************************************
  always @(posedge i_mclk) begin
    if (o_wreg_we === 1'b1 || o_file_we === 1'b1) begin
      n_wr++;
      wr_f = o_file_we;
      wr_q = o_file_we ? o_file_wdata : o_wreg_wdata;
    end
    if (o_flag_we === 1'b1) fl_q = o_flags;
    if (o_skip === 1'b1) n_skip++;
    if (o_busy === 1'b1) n_busy++;
    if (o_file_re === 1'b1) ra_q = o_file_addr;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One slot per instruction, then idle clocks so results settle
  task automatic issue(input logic [15:0] op, input int idle);
    i_instr <= op;
    i_instr_vld <= 1'b1;
    repeat (4) @(posedge i_mclk);
    if (idle > 0) begin
      i_instr_vld <= 1'b0;
      repeat (idle) @(posedge i_mclk);
    end
  endtask : issue
  task automatic t_xlw;
    logic [7:0] k [3] = '{8'hAF, 8'hB5, 8'h4A};
    logic [7:0] r;
    int c;
    i_wreg <= 8'hB5;
    foreach (k[j]) begin
      r = 8'hB5 ^ k[j];
      c = n_wr;
      issue({8'h0A, k[j]}, 8);
      chk("xor_literal_op count", c + 1, n_wr);
      chk("xor_literal_op data", r, wr_q);
      chk("xor_literal_op flags", {r == 8'h00, r[7]}, fl_q);
    end
    $display("test xor literal done");
  endtask : t_xlw
  task automatic t_xwf;
    int c;
    for (int d = 0; d < 2; d++) begin
      i_file_rdata <= 8'hAF;
      c = n_wr;
      issue({6'h06, d[0], d[0], 8'h3C}, 0);
      // Freeze two whole slots so the phase stays aligned
      i_ce <= 1'b0;
      i_instr_vld <= 1'b0;
      repeat (8) @(posedge i_mclk);
      chk("xor_file_op frozen", c, n_wr);
      i_ce <= 1'b1;
      repeat (8) @(posedge i_mclk);
      chk("xor_file_op count", c + 1, n_wr);
      chk("xor_file_op addr", {d[0], 8'h3C}, ra_q);
      chk("xor_file_op dest", d, wr_f);
      chk("xor_file_op data", 8'h1A, wr_q);
      chk("xor_file_op flags", 2'h0, fl_q);
    end
    $display("test xor file done");
  endtask : t_xwf
  task automatic t_tst;
    logic [7:0] v [3] = '{8'h5A, 8'h00, 8'h00};
    int c, s;
    foreach (v[j]) begin
      c = n_wr;
      s = n_skip;
      i_file_rdata <= v[j];
      i_next_two_word <= (j == 2);
      issue({7'h33, 1'b0, 8'h21}, 0);
      repeat (2) issue(16'h0A0F, 0);
      issue(16'h0A0F, 12);
      chk("tst addr", 9'h021, ra_q);
      chk("tst writes", 3 - j, n_wr - c);
      chk("tst skip", j > 0, n_skip - s);
    end
    $display("test skip zero done");
  endtask : t_tst
  task automatic t_tbl;
    logic [15:0] op [8] = '{16'h0009, 16'h0008, 16'h000B, 16'h000A,
                            16'h000F, 16'h000E, 16'h000D, 16'h000C};
    logic [20:0] tp, a;
    logic [7:0] lat;
    int b;
    tp = '0;
    lat = '0;
    foreach (op[j]) begin
      if (op[j][1:0] == 2'h3) tp = tp + 1;
      a = tp;
      if (op[j][1:0] == 2'h1) tp = tp + 1;
      if (op[j][1:0] == 2'h2) tp = tp - 1;
      b = n_busy;
      issue(op[j], 12);
      // One extra instruction cycle of four clocks
      chk("busy cycles", 4, n_busy - b);
      chk("pointer", tp, o_table_pointer);
      if (op[j][2]) begin
        chk("hold addr", a, wa);
        chk("hold data", lat, wd);
      end else begin
        lat = a[0] ? a[8:1] ^ 8'hC3 : ~a[8:1];
        chk("latch", lat, o_table_latch);
      end
    end
    $display("test table access done");
  endtask : t_tbl
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge i_mclk);
    i_srst <= 1'b0;
    chk("reset pointer", 21'h0, o_table_pointer);
    t_xlw();
    t_xwf();
    t_tst();
    t_tbl();
    results();
  end
  // Whole run is well under a thousand clocks
  initial begin
    repeat (4000) @(posedge i_mclk);
    n_mismatch++;
    results();
  end
endmodule : table_access_xor_test_ops_tb
`default_nettype wire
